//--- monitor_irq_defines.vh
`ifndef MONITOR_IRQ_DEFINES_VH
`define MONITOR_IRQ_DEFINES_VH

// register indices; byte address is four times the index
`define IDX_CONFIG 7'h40
`define IDX_STATUS_ONE 7'h41
`define IDX_STATUS_TWO 7'h42
`define IDX_MGMT_MASK_ONE 7'h43
`define IDX_MGMT_MASK_TWO 7'h44
`define IDX_HOST_MASK_ONE 7'h45
`define IDX_HOST_MASK_TWO 7'h46

// configuration fields
`define CFG_INIT 7
`define CFG_PULSE_FORM 6
`define CFG_ACTIVE_LOW 5
`define CFG_SUPPRESS 3
`define CFG_HOST_ENABLE 2
`define CFG_MGMT_ENABLE 1
`define CFG_START 0
`define CFG_WRITE_MASK 8'h6f

// reset values and the status two used-bit mask
`define CFG_RESET 8'h01
`define STATUS_RESET 8'h00
`define MASK_RESET 8'h00
`define STATUS_TWO_USED 8'h7f

// status bit positions, register one
`define ST1_FAN_TWO 7
`define ST1_FAN_ONE 6
`define ST1_TEMP_TWO 5
`define ST1_TEMP_ONE 4
`define ST1_FIVE_VOLT 3
`define ST1_THREE_VOLT 2
`define ST1_AUX_ZERO 1
`define ST1_CORE 0

// status bit positions, register two
`define ST2_AUX_ONE 6
`define ST2_TEMP_THREE 5
`define ST2_CHASSIS 4
`define ST2_FAN_THREE 3
`define ST2_MINUS_FIVE 2
`define ST2_MINUS_TWELVE 1
`define ST2_PLUS_TWELVE 0

// host interrupt pulse length in clock cycles
`define HOST_PULSE_CYCLES 4'h4
`define PULSE_IDLE 4'h0

`endif

//--- event_latch.v
`timescale 1ns/10ps
`default_nettype none
`include "monitor_irq_defines.vh"

// sticky event bits; a new event wins over a clear in the same cycle
module event_latch (
	input wire clk, // system clock
	input wire rst, // async reset, active high
	input wire [7:0] set_in, // one-cycle or level events
	input wire clear, // drop all bits
	output reg [7:0] value_q // latched events
);

	wire [7:0] value_d;

	assign value_d = (clear ? `STATUS_RESET : value_q) | set_in;

	always @(posedge clk or posedge rst)
	begin
		if (rst)
			value_q <= `STATUS_RESET;
		else
			value_q <= value_d;
	end

endmodule

`default_nettype wire

//--- monitor_interrupt_control.v
// What this block does
// (R1) config bit 7 reloads defaults, then self-clears
// (R2) config bit 6: level or low pulse
// (R3) config bit 5: host level-form polarity, default high
// (R4) suppress bit holds both outputs inactive
// (R5) suppress bit halts monitoring until cleared
// (R6) config bit 2 enables host interrupt
// (R7) config bit 1 enables management interrupt
// (R8) config bit 0 runs monitoring, else standby
// (R9) clearing start leaves interrupt outputs asserted
// (R10) configuration resets to 01h
// (R11) status one bits 7,6: fan limits
// (R12) status one bits 5,4: temperature highs
// (R13) status one bits 3..0: voltage excursions
// (R14) status two voltage and fan three bits
// (R15) status two bit 5: temperature three
// (R16) status two bit 4: chassis intrusion; 7 reserved
// (R17) status and management masks reset 00h
// (R18) management mask bit blocks matching status bit
// (R19) host mask registers block host interrupt
// (R20) output asserts on unmasked, enabled, unsuppressed status
//
// Design decision made here: the Wishbone slave port.
`timescale 1ns/10ps
`include "monitor_irq_defines.vh"
`default_nettype none

module monitor_interrupt_control (
	input wire clk, // 25 MHz system clock
	input wire rst, // async reset, active high
	input wire wb_cyc_i, // wishbone cycle
	input wire wb_stb_i, // wishbone strobe
	input wire wb_we_i, // wishbone write
	input wire [8:0] wb_adr_i, // byte address
	input wire [3:0] wb_sel_i, // byte lanes
	input wire [31:0] wb_dat_i, // write data
	output reg [31:0] wb_dat_o, // read data
	output reg wb_ack_o, // transfer acknowledge
	input wire core_voltage_over, // core voltage out of limits
	input wire aux_voltage_zero_over, // aux voltage zero out of limits
	input wire three_volt_input_over, // 3.3 V out of limits
	input wire five_volt_supply_over, // 5 V out of limits
	input wire temp_input_one_high, // temperature one above high limit
	input wire temp_input_two_high, // temperature two above high limit
	input wire fan_one_over, // fan one count limit exceeded
	input wire fan_two_over, // fan two count limit exceeded
	input wire plus_twelve_input_over, // +12 V out of limits
	input wire minus_twelve_input_over, // -12 V out of limits
	input wire minus_five_input_over, // -5 V out of limits
	input wire fan_three_over, // fan three count limit exceeded
	input wire temp_input_three_over, // temperature three out of limits
	input wire aux_voltage_one_over, // aux voltage one out of limits
	input wire chassis_intrusion, // asynchronous intrusion pin
	output reg monitor_run_q, // measurement logic may run
	output reg mgmt_irq_n, // management interrupt, active low
	output reg host_irq_q // host interrupt, form and polarity per config
);

	// bus request decode
	reg [7:0] cfg_q;
	reg [7:0] mgmt_mask_one_q;
	reg [7:0] mgmt_mask_two_q;
	reg [7:0] host_mask_one_q;
	reg [7:0] host_mask_two_q;
	wire [7:0] status_one;
	wire [7:0] status_two;
	wire [6:0] index;
	wire take;
	wire wr_lane;
	wire rd_take;
	wire init_req;
	wire wr_cfg;
	wire wr_mgmt_one;
	wire wr_mgmt_two;
	wire wr_host_one;
	wire wr_host_two;
	wire rd_status_one;
	wire rd_status_two;
	reg [7:0] rd_byte;

	assign index = wb_adr_i[8:2];
	assign take = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	assign wr_lane = take & wb_we_i & wb_sel_i[0];
	assign rd_take = take & ~wb_we_i;
	assign init_req = wr_cfg & wb_dat_i[`CFG_INIT];
	// one strobe per register; a write with lane 0 off is acked and dropped
	assign wr_cfg = wr_lane & (index == `IDX_CONFIG);
	assign wr_mgmt_one = wr_lane & (index == `IDX_MGMT_MASK_ONE);
	assign wr_mgmt_two = wr_lane & (index == `IDX_MGMT_MASK_TWO);
	assign wr_host_one = wr_lane & (index == `IDX_HOST_MASK_ONE);
	assign wr_host_two = wr_lane & (index == `IDX_HOST_MASK_TWO);
	assign rd_status_one = rd_take & (index == `IDX_STATUS_ONE);
	assign rd_status_two = rd_take & (index == `IDX_STATUS_TWO);

	// classic single-cycle answer: ack one edge after the request is seen
	always @(posedge clk or posedge rst)
	begin
		if (rst)
			wb_ack_o <= 1'b0;
		else
			wb_ack_o <= take;
	end

	always @*
	begin
		case (index)
			`IDX_CONFIG: rd_byte = cfg_q;
			`IDX_STATUS_ONE: rd_byte = status_one;
			`IDX_STATUS_TWO: rd_byte = status_two;
			`IDX_MGMT_MASK_ONE: rd_byte = mgmt_mask_one_q;
			`IDX_MGMT_MASK_TWO: rd_byte = mgmt_mask_two_q;
			`IDX_HOST_MASK_ONE: rd_byte = host_mask_one_q;
			`IDX_HOST_MASK_TWO: rd_byte = host_mask_two_q;
			default: rd_byte = `STATUS_RESET;
		endcase
	end

	// read data is zero outside an acked read
	always @(posedge clk or posedge rst)
	begin
		if (rst)
			wb_dat_o <= 32'h0000_0000;
		else if (rd_take)
			wb_dat_o <= {24'h00_0000, rd_byte};
		else
			wb_dat_o <= 32'h0000_0000;
	end

	// configuration register
	always @(posedge clk or posedge rst)
	begin
		if (rst)
			cfg_q <= `CFG_RESET; // [R10]
		else if (init_req)
			cfg_q <= `CFG_RESET; // [R1]
		else if (wr_cfg)
			cfg_q <= wb_dat_i[7:0] & `CFG_WRITE_MASK;
	end

	// mask registers; initialisation returns them to zero as well
	always @(posedge clk or posedge rst)
	begin
		if (rst)
			mgmt_mask_one_q <= `MASK_RESET; // [R17]
		else if (init_req)
			mgmt_mask_one_q <= `MASK_RESET; // [R1]
		else if (wr_mgmt_one)
			mgmt_mask_one_q <= wb_dat_i[7:0]; // [R18]
	end

	always @(posedge clk or posedge rst)
	begin
		if (rst)
			mgmt_mask_two_q <= `MASK_RESET; // [R17]
		else if (init_req)
			mgmt_mask_two_q <= `MASK_RESET; // [R1]
		else if (wr_mgmt_two)
			mgmt_mask_two_q <= wb_dat_i[7:0] & `STATUS_TWO_USED; // [R18]
	end

	always @(posedge clk or posedge rst)
	begin
		if (rst)
			host_mask_one_q <= `MASK_RESET; // [R19]
		else if (init_req)
			host_mask_one_q <= `MASK_RESET; // [R1]
		else if (wr_host_one)
			host_mask_one_q <= wb_dat_i[7:0]; // [R19]
	end

	always @(posedge clk or posedge rst)
	begin
		if (rst)
			host_mask_two_q <= `MASK_RESET; // [R19]
		else if (init_req)
			host_mask_two_q <= `MASK_RESET; // [R1]
		else if (wr_host_two)
			host_mask_two_q <= wb_dat_i[7:0] & `STATUS_TWO_USED; // [R19]
	end

	// monitoring runs only while started and not suppressed
	wire running;

	assign running = cfg_q[`CFG_START] & ~cfg_q[`CFG_SUPPRESS]; // [R5] [R8]

	always @(posedge clk or posedge rst)
	begin
		if (rst)
			monitor_run_q <= 1'b0;
		else
			monitor_run_q <= running;
	end

	// intrusion pin: three flops, a change counts once the last two agree
	// a pin pulse shorter than two clocks never counts
	reg intr_s1_q;
	reg intr_s2_q;
	reg intr_s3_q;
	reg intr_level_q;

	always @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			intr_s1_q <= 1'b0;
			intr_s2_q <= 1'b0;
			intr_s3_q <= 1'b0;
			intr_level_q <= 1'b0;
		end
		else
		begin
			intr_s1_q <= chassis_intrusion;
			intr_s2_q <= intr_s1_q;
			intr_s3_q <= intr_s2_q;
			if (intr_s2_q == intr_s3_q)
				intr_level_q <= intr_s3_q;
		end
	end

	// event sources; measured events count only while monitoring runs
	reg [7:0] set_one;
	reg [7:0] set_two;

	always @*
	begin
		set_one = `STATUS_RESET;
		set_two = `STATUS_RESET;
		set_one[`ST1_FAN_TWO] = fan_two_over; // [R11]
		set_one[`ST1_FAN_ONE] = fan_one_over; // [R11]
		set_one[`ST1_TEMP_TWO] = temp_input_two_high; // [R12]
		set_one[`ST1_TEMP_ONE] = temp_input_one_high; // [R12]
		set_one[`ST1_FIVE_VOLT] = five_volt_supply_over; // [R13]
		set_one[`ST1_THREE_VOLT] = three_volt_input_over; // [R13]
		set_one[`ST1_AUX_ZERO] = aux_voltage_zero_over; // [R13]
		set_one[`ST1_CORE] = core_voltage_over; // [R13]
		set_two[`ST2_AUX_ONE] = aux_voltage_one_over; // [R14]
		set_two[`ST2_TEMP_THREE] = temp_input_three_over; // [R15]
		set_two[`ST2_FAN_THREE] = fan_three_over; // [R14]
		set_two[`ST2_MINUS_FIVE] = minus_five_input_over; // [R14]
		set_two[`ST2_MINUS_TWELVE] = minus_twelve_input_over; // [R14]
		set_two[`ST2_PLUS_TWELVE] = plus_twelve_input_over; // [R14]
		if (!running)
		begin
			set_one = `STATUS_RESET;
			set_two = `STATUS_RESET;
		end
		// intrusion is a pin, not a measurement, so standby does not hide it
		set_two[`ST2_CHASSIS] = intr_level_q; // [R16]
	end

	// status is read-only; a read drops it, a concurrent event survives
	wire clr_one;
	wire clr_two;

	assign clr_one = init_req | rd_status_one;
	assign clr_two = init_req | rd_status_two;

	event_latch status_one_latch (
		.clk(clk),
		.rst(rst),
		.set_in(set_one),
		.clear(clr_one),
		.value_q(status_one)
	); // [R17]

	event_latch status_two_latch (
		.clk(clk),
		.rst(rst),
		.set_in(set_two & `STATUS_TWO_USED),
		.clear(clr_two),
		.value_q(status_two)
	); // [R16]

	// pending terms per output; the start bit plays no part here,
	// so stopping monitoring leaves a raised interrupt standing
	wire mgmt_pend;
	wire host_pend;

	assign mgmt_pend = |((status_one & ~mgmt_mask_one_q) | (status_two & ~mgmt_mask_two_q)); // [R18]
	assign host_pend = |((status_one & ~host_mask_one_q) | (status_two & ~host_mask_two_q)); // [R19]

	wire mgmt_active;
	wire host_active;

	assign mgmt_active = mgmt_pend & cfg_q[`CFG_MGMT_ENABLE] & ~cfg_q[`CFG_SUPPRESS]; // [R7] [R4] [R20] [R9]
	assign host_active = host_pend & cfg_q[`CFG_HOST_ENABLE] & ~cfg_q[`CFG_SUPPRESS]; // [R6] [R4] [R20] [R9]

	always @(posedge clk or posedge rst)
	begin
		if (rst)
			mgmt_irq_n <= 1'b1;
		else
			mgmt_irq_n <= ~mgmt_active; // [R20]
	end

	// host pulse form: one low pulse of fixed length per new assertion
	// a pulse cut short by a status read is not replayed; one cut short by suppress restarts in full if status is still pending when suppress clears
	reg host_prev_q;
	reg [3:0] pulse_cnt_q;
	reg [3:0] pulse_cnt_d;
	reg host_irq_d;

	always @*
	begin
		pulse_cnt_d = pulse_cnt_q;
		if (!host_active)
			pulse_cnt_d = `PULSE_IDLE; // [R4]
		else if (!host_prev_q)
			pulse_cnt_d = `HOST_PULSE_CYCLES;
		else if (pulse_cnt_q != `PULSE_IDLE)
			pulse_cnt_d = pulse_cnt_q - 4'h1;
	end

	// pulse form ignores polarity; the pulse is always low-going
	always @*
	begin
		if (cfg_q[`CFG_PULSE_FORM])
			host_irq_d = (pulse_cnt_d == `PULSE_IDLE); // [R2]
		else if (cfg_q[`CFG_ACTIVE_LOW])
			host_irq_d = ~host_active; // [R3]
		else
			host_irq_d = host_active; // [R2] [R3] [R20]
	end

	always @(posedge clk or posedge rst)
	begin
		if (rst)
			host_prev_q <= 1'b0;
		else
			host_prev_q <= host_active;
	end

	always @(posedge clk or posedge rst)
	begin
		if (rst)
			pulse_cnt_q <= `PULSE_IDLE;
		else
			pulse_cnt_q <= pulse_cnt_d;
	end

	always @(posedge clk or posedge rst)
	begin
		if (rst)
			host_irq_q <= 1'b0;
		else
			host_irq_q <= host_irq_d; // [R2] [R3]
	end

endmodule

`default_nettype wire

//--- irq_chk.sv
`timescale 1ns/10ps
`default_nettype none
module irq_chk (
	input wire logic clk, // clock
	input wire logic rst, // reset
	input wire logic wb_cyc_i, // cycle
	input wire logic wb_stb_i, // strobe
	input wire logic wb_we_i, // write
	input wire logic [8:0] wb_adr_i, // address
	input wire logic [3:0] wb_sel_i, // byte lanes
	input wire logic [31:0] wb_dat_i, // write data
	input wire logic [31:0] wb_dat_o, // read data
	input wire logic wb_ack_o, // ack
	input wire logic monitor_run_q, // run
	input wire logic mgmt_irq_n, // mgmt irq
	input wire logic host_irq_q // host irq
);
	logic [7:0] cfg_q;
	logic rd_cfg_q;
	wire logic take_cfg = wb_cyc_i & wb_stb_i & !wb_ack_o & (wb_adr_i[8:2] == 7'h40);
	// shadow config, written only through byte lane 0
	always @(posedge clk or posedge rst)
		if (rst)
		begin
			cfg_q <= 8'h01;
			rd_cfg_q <= 1'b0;
		end
		else
		begin
			rd_cfg_q <= take_cfg & !wb_we_i;
			if (take_cfg & wb_we_i & wb_sel_i[0])
				cfg_q <= wb_dat_i[7] ? 8'h01 : wb_dat_i[7:0] & 8'h6f;
		end
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	property p_ack_lat; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
	a_ack_lat: assert property (p_ack_lat) else $error("ack late");
	property p_ack_one; wb_ack_o |=> !wb_ack_o; endproperty
	a_ack_one: assert property (p_ack_one) else $error("ack too long");
	property p_dat_idle; !wb_ack_o |-> wb_dat_o == 32'h0000_0000; endproperty
	a_dat_idle: assert property (p_dat_idle) else $error("read data without ack");
	property p_cfg_read; rd_cfg_q |-> wb_ack_o && wb_dat_o == {24'h00_0000, cfg_q}; endproperty
	a_cfg_read: assert property (p_cfg_read) else $error("config readback");
	property p_run; !$past(rst) && $stable(cfg_q) |-> monitor_run_q == (cfg_q[0] && !cfg_q[3]); endproperty
	a_run: assert property (p_run) else $error("run flag");
	property p_supp; cfg_q[3] ##1 $stable(cfg_q) |-> mgmt_irq_n && host_irq_q == (cfg_q[5] || cfg_q[6]); endproperty
	a_supp: assert property (p_supp) else $error("suppress");
	property p_mgmt_off; !cfg_q[1] |=> mgmt_irq_n; endproperty
	a_mgmt_off: assert property (p_mgmt_off) else $error("mgmt disabled");
	property p_host_off; !cfg_q[2] ##1 $stable(cfg_q) |-> host_irq_q == (cfg_q[5] || cfg_q[6]); endproperty
	a_host_off: assert property (p_host_off) else $error("host disabled");
	property p_pulse; $fell(host_irq_q) && cfg_q[6] |-> !host_irq_q [*4] ##1 host_irq_q; endproperty
	a_pulse: assert property (p_pulse) else $error("pulse width");
endmodule
`default_nettype wire

//--- irq_sink.sv
`timescale 1ns/10ps
`default_nettype none
// host receiver; 4-bit count wraps, so only short low runs are measured
module irq_sink (
	input wire logic clk, // clock
	input wire logic rst, // reset
	input wire logic host_irq_q, // host irq line
	output logic [3:0] low_len // last low run
);
	logic [3:0] cnt_q;
	always @(posedge clk or posedge rst)
		if (rst)
		begin
			cnt_q <= 4'h0;
			low_len <= 4'h0;
		end
		else if (!host_irq_q)
			cnt_q <= cnt_q + 4'h1;
		else if (cnt_q != 4'h0)
		begin
			low_len <= cnt_q;
			cnt_q <= 4'h0;
		end
endmodule
`default_nettype wire

//--- tb.sv
`timescale 1ns/10ps
`default_nettype none
module tb;
	logic clk, rst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, monitor_run_q, mgmt_irq_n, host_irq_q;
	logic [8:0] wb_adr_i;
	logic [3:0] wb_sel_i, low_len;
	logic [31:0] wb_dat_i, wb_dat_o;
	logic [14:0] ev;
	int n_fail, checks;
	monitor_interrupt_control DUT (.clk(clk), .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
		.wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
		.wb_ack_o(wb_ack_o), .core_voltage_over(ev[0]), .aux_voltage_zero_over(ev[1]),
		.three_volt_input_over(ev[2]), .five_volt_supply_over(ev[3]), .temp_input_one_high(ev[4]),
		.temp_input_two_high(ev[5]), .fan_one_over(ev[6]), .fan_two_over(ev[7]), .plus_twelve_input_over(ev[8]),
		.minus_twelve_input_over(ev[9]), .minus_five_input_over(ev[10]), .fan_three_over(ev[11]),
		.chassis_intrusion(ev[12]), .temp_input_three_over(ev[13]), .aux_voltage_one_over(ev[14]),
		.monitor_run_q(monitor_run_q), .mgmt_irq_n(mgmt_irq_n), .host_irq_q(host_irq_q));
	irq_sink sink (.clk(clk), .rst(rst), .host_irq_q(host_irq_q), .low_len(low_len));
	initial
	begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	task automatic chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
		checks++;
		if (got !== exp)
		begin
			n_fail++;
			$display("[ERR] %s exp %h got %h", nm, exp, got);
		end
	endtask
	task automatic bus(input logic we, input logic [8:0] a, input logic [7:0] d, input logic [3:0] s,
		output logic [7:0] q);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= a;
		wb_sel_i <= s;
		wb_dat_i <= {24'h00_0000, d};
		// no limit of its own: only the watchdog ends a wait for ack
		do
			@(posedge clk);
		while (wb_ack_o !== 1'b1);
		q = wb_dat_o[7:0];
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		@(posedge clk);
	endtask
	task automatic wr_sel(input logic [8:0] a, input logic [7:0] d, input logic [3:0] s);
		logic [7:0] q;
		bus(1'b1, a, d, s, q);
	endtask
	task automatic wr(input logic [8:0] a, input logic [7:0] d);
		wr_sel(a, d, 4'h1);
	endtask
	task automatic rd(input logic [8:0] a, input logic [7:0] e, input string nm);
		logic [7:0] q;
		bus(1'b0, a, 8'h00, 4'h1, q);
		chk(nm, q, e);
	endtask
	// two-cycle event, so the intrusion filter passes it; the wait covers its synchroniser
	task automatic hit(input int i);
		ev[i] <= 1'b1;
		repeat (2) @(posedge clk);
		ev <= 15'h0000;
		repeat (5) @(posedge clk);
	endtask
	task end_of_test;
		$display("checks %0d n_fail %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	initial
	begin
		repeat (5000) @(posedge clk);
		n_fail++;
		end_of_test();
	end
	initial
	begin
		rst = 1'b1;
		wb_cyc_i = 1'b0;
		wb_stb_i = 1'b0;
		wb_we_i = 1'b0;
		wb_adr_i = 9'h000;
		wb_sel_i = 4'h1;
		wb_dat_i = 32'h0000_0000;
		ev = 15'h0000;
		n_fail = 0;
		checks = 0;
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		rd(9'h100, 8'h01, "config");
		for (int a = 1; a < 7; a++)
			rd(9'(9'h100 + 4 * a), 8'h00, "reg_reset");
		for (int i = 0; i < 15; i++)
		begin
			hit(i);
			rd(9'h104, (i < 8) ? 8'h01 << i : 8'h00, "st1");
			rd(9'h108, (i < 8) ? 8'h00 : 8'h01 << (i - 8), "st2");
		end
		wr(9'h104, 8'hff);
		wr(9'h110, 8'hff);
		rd(9'h104, 8'h00, "st1");
		rd(9'h110, 8'h7f, "mask2");
		wr_sel(9'h110, 8'h00, 4'h0);
		rd(9'h110, 8'h7f, "mask2_sel");
		wr(9'h100, 8'h07);
		wr(9'h10c, 8'h01);
		hit(0);
		chk("mgmt", mgmt_irq_n, 1'b1);
		chk("host", host_irq_q, 1'b1);
		hit(1);
		chk("mgmt", mgmt_irq_n, 1'b0);
		wr(9'h114, 8'h03);
		chk("host", host_irq_q, 1'b0);
		wr(9'h114, 8'h00);
		wr(9'h100, 8'h2f);
		chk("host", host_irq_q, 1'b1);
		chk("run", monitor_run_q, 1'b0);
		rd(9'h104, 8'h03, "st1");
		hit(0);
		rd(9'h104, 8'h00, "st1");
		wr(9'h100, 8'h27);
		hit(1);
		chk("host", host_irq_q, 1'b0);
		wr(9'h100, 8'h26);
		chk("host", host_irq_q, 1'b0);
		chk("mgmt", mgmt_irq_n, 1'b0);
		rd(9'h104, 8'h02, "st1");
		hit(1);
		rd(9'h104, 8'h00, "st1");
		wr(9'h100, 8'h45);
		hit(0);
		repeat (6) @(posedge clk);
		chk("low_len", low_len, 8'h04);
		wr_sel(9'h100, 8'h80, 4'h0);
		rd(9'h100, 8'h45, "config_sel");
		wr(9'h100, 8'h80);
		rd(9'h100, 8'h01, "config");
		rd(9'h110, 8'h00, "mask2");
		rd(9'h1fc, 8'h00, "unmapped");
		end_of_test();
	end
endmodule
bind monitor_interrupt_control irq_chk chk (.clk(clk), .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
	.wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
	.wb_ack_o(wb_ack_o),
	.monitor_run_q(monitor_run_q), .mgmt_irq_n(mgmt_irq_n), .host_irq_q(host_irq_q));
`default_nettype wire
